// ### verilog/vah_defines.vh
`ifndef VAH_DEFINES_VH
`define VAH_DEFINES_VH

// Register byte offsets
`define VAH_OFF_CTRL      8'h00
`define VAH_OFF_ACT_VOLT  8'h04
`define VAH_OFF_PICKUP    8'h08
`define VAH_OFF_HOLD_TIME 8'h0C
`define VAH_OFF_FIX_FREQ  8'h10
`define VAH_OFF_STATE     8'h14
`define VAH_OFF_EVT_STAT  8'h18
`define VAH_OFF_EVT_CLR   8'h1C
`define VAH_OFF_EVT_EN    8'h20

// Control field positions
`define VAH_CTRL_ENABLE   0
`define VAH_CTRL_CUR_EN   1
`define VAH_CTRL_FOLLOW   2
`define VAH_CTRL_USE_LSB  4
`define VAH_CTRL_USE_MSB  6

// Reset values
`define VAH_RST_CTRL      32'h00000070
`define VAH_RST_ACT_VOLT  16'h07D0
`define VAH_RST_PICKUP    16'h0064
`define VAH_RST_HOLD_TIME 16'h0032
`define VAH_RST_FIX_FREQ  16'h1388

// Threshold limits, 0.01 V units (2 V .. 50 V)
`define VAH_ACT_VOLT_MIN  16'h00C8
`define VAH_ACT_VOLT_MAX  16'h1388

// Hold time limits, 10 ms units (0.02 s .. 50.00 s)
`define VAH_HOLD_MIN      16'h0002
`define VAH_HOLD_MAX      16'h1388

// Timer tick
`define VAH_CLK_PERIOD_NS 40
`define VAH_TICK_NS       10000000

// Event bit positions
`define VAH_EV_ENABLED    0
`define VAH_EV_DISABLED   1
`define VAH_EV_VLOW_ON    2
`define VAH_EV_VLOW_OFF   3
`define VAH_EV_IHIGH_ON   4
`define VAH_EV_IHIGH_OFF  5
`define VAH_EV_FTRK_ON    6
`define VAH_EV_FTRK_OFF   7
`define VAH_EV_HOLD_ON    8
`define VAH_EV_HOLD_OFF   9
`define VAH_EV_BLK_ON     10
`define VAH_EV_BLK_OFF    11
`define VAH_EV_W          12

`endif

// ### verilog/vah_voltage_hold.v
// Function
// - With the function enabled, the voltage condition holds only while every used voltage is below the threshold.
// - The activation threshold is settable from 2 V to 50 V and measured voltages are compared against it.
// - With the current condition enabled, at least one phase current must also exceed the pickup setting.
// - While the hold is active the threshold value is given out as the voltage amplitude.
// - Healthy angles are tracked continuously and the last pre-fault angles are frozen on activation.
// - A hold-in-use output is high for as long as the hold is active.
// - A definite-time timer, settable from 0.02 s to 50.00 s, limits the active period.
// - On timer expiry the memorised voltage is dropped and the stages are told to use fallback tripping.
// - The blocking input is sampled at each program cycle start and inhibits the hold while asserted.
// - With frequency following on and voltages absent, sampling frequency comes from the phase three current.
// - ON and OFF events are raised when the low-voltage condition rises and falls.
// - ON and OFF events are raised when the high-current condition rises and falls.
// - ON and OFF events are raised when current frequency following starts and stops.
// - ON and OFF events mark hold start and end, and separate events mark enable and disable.
// - ON and OFF events are raised when the block asserts and releases.
`timescale 1ns/1ps
`include "vah_defines.vh"

module vah_voltage_hold #(
  parameter TICK_CYCLES = `VAH_TICK_NS / `VAH_CLK_PERIOD_NS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        cycle_start,
  input  wire        block_in,
  input  wire [15:0] volt_mag_1,
  input  wire [15:0] volt_mag_2,
  input  wire [15:0] volt_mag_3,
  input  wire [15:0] volt_ang_1,
  input  wire [15:0] volt_ang_2,
  input  wire [15:0] volt_ang_3,
  input  wire [15:0] cur_mag_1,
  input  wire [15:0] cur_mag_2,
  input  wire [15:0] cur_mag_3,
  input  wire [15:0] phase_three_current_freq,
  output reg  [15:0] volt_amp_out_1,
  output reg  [15:0] volt_amp_out_2,
  output reg  [15:0] volt_amp_out_3,
  output reg  [15:0] volt_ang_out_1,
  output reg  [15:0] volt_ang_out_2,
  output reg  [15:0] volt_ang_out_3,
  output reg         voltage_hold_on,
  output reg         fallback_mode,
  output reg         current_frequency_follow,
  output reg  [15:0] sample_freq,
  output wire        irq
);

  localparam [1:0] ST_IDLE    = 2'b00;
  localparam [1:0] ST_ACTIVE  = 2'b01;
  localparam [1:0] ST_EXPIRED = 2'b10;
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [17:0]  TICK_LAST   = TICK_LAST_I[17:0];

  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [31:0] merge_strb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge_strb = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_strb[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Register file
  reg [31:0] ctrl_q;
  reg [15:0] act_volt_q;
  reg [15:0] pickup_q;
  reg [15:0] hold_time_q;
  reg [15:0] fix_freq_q;
  reg [11:0] evt_stat_q;
  reg [11:0] evt_en_q;

  // AXI write path
  reg        aw_full_q;
  reg [7:0]  aw_addr_q;
  reg        w_full_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  wire [31:0] ctrl_wr = merge_strb(ctrl_q, w_data_q, w_strb_q);
  wire [31:0] volt_wr = merge_strb({16'h0000, act_volt_q}, w_data_q, w_strb_q);
  wire [31:0] pick_wr = merge_strb({16'h0000, pickup_q}, w_data_q, w_strb_q);
  wire [31:0] hold_wr = merge_strb({16'h0000, hold_time_q}, w_data_q, w_strb_q);
  wire [31:0] freq_wr = merge_strb({16'h0000, fix_freq_q}, w_data_q, w_strb_q);
  wire [31:0] eren_wr = merge_strb({20'h00000, evt_en_q}, w_data_q, w_strb_q);
  wire [31:0] clr_wr  = merge_strb(32'h00000000, w_data_q, w_strb_q);

  reg         addr_ok;
  always @* begin
    case (aw_addr_q)
      `VAH_OFF_CTRL, `VAH_OFF_ACT_VOLT, `VAH_OFF_PICKUP, `VAH_OFF_HOLD_TIME,
      `VAH_OFF_FIX_FREQ, `VAH_OFF_EVT_CLR, `VAH_OFF_EVT_EN: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  wire [11:0] evt_clr = (wr_fire && aw_addr_q == `VAH_OFF_EVT_CLR) ? clr_wr[11:0] : 12'h000;
  wire [11:0] events;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q    <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_full_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      ctrl_q       <= `VAH_RST_CTRL;
      act_volt_q   <= `VAH_RST_ACT_VOLT;
      pickup_q     <= `VAH_RST_PICKUP;
      hold_time_q  <= `VAH_RST_HOLD_TIME;
      fix_freq_q   <= `VAH_RST_FIX_FREQ;
      evt_en_q     <= 12'h000;
      evt_stat_q   <= 12'h000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_ok ? 2'b00 : 2'b10;
        case (aw_addr_q)
          `VAH_OFF_CTRL:      ctrl_q      <= {25'h0000000, ctrl_wr[6:4], 1'b0, ctrl_wr[2:0]};
          `VAH_OFF_ACT_VOLT:  act_volt_q  <= clamp16(volt_wr[15:0], `VAH_ACT_VOLT_MIN, `VAH_ACT_VOLT_MAX);
          `VAH_OFF_PICKUP:    pickup_q    <= pick_wr[15:0];
          `VAH_OFF_HOLD_TIME: hold_time_q <= clamp16(hold_wr[15:0], `VAH_HOLD_MIN, `VAH_HOLD_MAX);
          `VAH_OFF_FIX_FREQ:  fix_freq_q  <= freq_wr[15:0];
          `VAH_OFF_EVT_EN:    evt_en_q    <= eren_wr[11:0];
          default: begin
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // A new event wins over a clear in the same cycle
      evt_stat_q <= (evt_stat_q & ~evt_clr) | events;
    end
  end

  assign irq = |(evt_stat_q & evt_en_q);

  // Protection logic
  wire       enable   = ctrl_q[`VAH_CTRL_ENABLE];
  wire       cur_en   = ctrl_q[`VAH_CTRL_CUR_EN];
  wire       follow   = ctrl_q[`VAH_CTRL_FOLLOW];
  wire [2:0] use_mask = ctrl_q[`VAH_CTRL_USE_MSB:`VAH_CTRL_USE_LSB];

  // Unused phases count as low; an empty mask never arms the hold
  wire [2:0] below = {volt_mag_3 < act_volt_q, volt_mag_2 < act_volt_q, volt_mag_1 < act_volt_q};
  wire       volt_low = enable && (use_mask != 3'b000) && ((below | ~use_mask) == 3'b111);
  wire       cur_high = (cur_mag_1 > pickup_q) || (cur_mag_2 > pickup_q) || (cur_mag_3 > pickup_q);
  wire       cur_ok   = !cur_en || cur_high;

  reg        blk_q;
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [17:0] tick_cnt_q;
  reg [15:0] hold_cnt_q;
  reg [15:0] ang_1_q;
  reg [15:0] ang_2_q;
  reg [15:0] ang_3_q;
  reg        enable_q;
  reg        vlow_q;
  reg        ihigh_q;
  reg        ftrk_q;
  reg        hold_q;
  reg        blk_prev_q;

  wire arm     = volt_low && cur_ok && !blk_q;
  wire expired = (state_q == ST_ACTIVE) && (hold_cnt_q >= hold_time_q);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (arm) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!arm) begin
          state_d = ST_IDLE;
        end else if (expired) begin
          state_d = ST_EXPIRED;
        end
      end
      ST_EXPIRED: begin
        // Stays in fallback until arm drops (voltage recovers, current condition fails or block asserts); no re-arm before then
        if (!arm) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  wire ftrk_d = follow && volt_low;

  always @(posedge aclk) begin
    if (!aresetn) begin
      blk_q      <= 1'b0;
      state_q    <= ST_IDLE;
      tick_cnt_q <= 18'h00000;
      hold_cnt_q <= 16'h0000;
      ang_1_q    <= 16'h0000;
      ang_2_q    <= 16'h0000;
      ang_3_q    <= 16'h0000;
    end else begin
      if (cycle_start) begin
        blk_q <= block_in;
      end
      state_q <= state_d;
      if (state_q != ST_ACTIVE) begin
        tick_cnt_q <= 18'h00000;
        hold_cnt_q <= 16'h0000;
      end else if (tick_cnt_q == TICK_LAST) begin
        tick_cnt_q <= 18'h00000;
        hold_cnt_q <= hold_cnt_q + 16'h0001;
      end else begin
        tick_cnt_q <= tick_cnt_q + 18'h00001;
      end
      // Track angles only while voltages are healthy, so the held copy predates the collapse
      if (state_q == ST_IDLE && !volt_low) begin
        ang_1_q <= volt_ang_1;
        ang_2_q <= volt_ang_2;
        ang_3_q <= volt_ang_3;
      end
    end
  end

  wire hold_d = (state_d == ST_ACTIVE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      volt_amp_out_1           <= 16'h0000;
      volt_amp_out_2           <= 16'h0000;
      volt_amp_out_3           <= 16'h0000;
      volt_ang_out_1           <= 16'h0000;
      volt_ang_out_2           <= 16'h0000;
      volt_ang_out_3           <= 16'h0000;
      voltage_hold_on          <= 1'b0;
      fallback_mode            <= 1'b0;
      current_frequency_follow <= 1'b0;
      sample_freq              <= `VAH_RST_FIX_FREQ;
    end else begin
      voltage_hold_on <= hold_d;
      fallback_mode   <= (state_d == ST_EXPIRED);
      if (hold_d) begin
        volt_amp_out_1 <= act_volt_q;
        volt_amp_out_2 <= act_volt_q;
        volt_amp_out_3 <= act_volt_q;
        volt_ang_out_1 <= ang_1_q;
        volt_ang_out_2 <= ang_2_q;
        volt_ang_out_3 <= ang_3_q;
      end else begin
        volt_amp_out_1 <= volt_mag_1;
        volt_amp_out_2 <= volt_mag_2;
        volt_amp_out_3 <= volt_mag_3;
        volt_ang_out_1 <= volt_ang_1;
        volt_ang_out_2 <= volt_ang_2;
        volt_ang_out_3 <= volt_ang_3;
      end
      current_frequency_follow <= ftrk_d;
      sample_freq <= ftrk_d ? phase_three_current_freq : fix_freq_q;
    end
  end

  // Edge detection for the event log
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_q   <= 1'b0;
      vlow_q     <= 1'b0;
      ihigh_q    <= 1'b0;
      ftrk_q     <= 1'b0;
      hold_q     <= 1'b0;
      blk_prev_q <= 1'b0;
    end else begin
      enable_q   <= enable;
      vlow_q     <= volt_low;
      ihigh_q    <= cur_high;
      ftrk_q     <= current_frequency_follow;
      hold_q     <= voltage_hold_on;
      blk_prev_q <= blk_q;
    end
  end

  assign events[`VAH_EV_ENABLED]   = enable && !enable_q;
  assign events[`VAH_EV_DISABLED]  = !enable && enable_q;
  assign events[`VAH_EV_VLOW_ON]   = volt_low && !vlow_q;
  assign events[`VAH_EV_VLOW_OFF]  = !volt_low && vlow_q;
  assign events[`VAH_EV_IHIGH_ON]  = cur_high && !ihigh_q;
  assign events[`VAH_EV_IHIGH_OFF] = !cur_high && ihigh_q;
  assign events[`VAH_EV_FTRK_ON]   = current_frequency_follow && !ftrk_q;
  assign events[`VAH_EV_FTRK_OFF]  = !current_frequency_follow && ftrk_q;
  assign events[`VAH_EV_HOLD_ON]   = voltage_hold_on && !hold_q;
  assign events[`VAH_EV_HOLD_OFF]  = !voltage_hold_on && hold_q;
  assign events[`VAH_EV_BLK_ON]    = blk_q && !blk_prev_q;
  assign events[`VAH_EV_BLK_OFF]   = !blk_q && blk_prev_q;

  // AXI read path
  reg [31:0] rd_mux;
  reg        rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `VAH_OFF_CTRL:      rd_mux = ctrl_q;
      `VAH_OFF_ACT_VOLT:  rd_mux = {16'h0000, act_volt_q};
      `VAH_OFF_PICKUP:    rd_mux = {16'h0000, pickup_q};
      `VAH_OFF_HOLD_TIME: rd_mux = {16'h0000, hold_time_q};
      `VAH_OFF_FIX_FREQ:  rd_mux = {16'h0000, fix_freq_q};
      `VAH_OFF_STATE:     rd_mux = {16'h0000, hold_cnt_q[15:0] & 16'hFFFF} << 0 | {25'h0000000, blk_q,
                                    current_frequency_follow, fallback_mode, voltage_hold_on, cur_high,
                                    volt_low, 1'b0} << 16;
      `VAH_OFF_EVT_STAT:  rd_mux = {20'h00000, evt_stat_q};
      `VAH_OFF_EVT_CLR:   rd_mux = 32'h00000000;
      `VAH_OFF_EVT_EN:    rd_mux = {20'h00000, evt_en_q};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // vah_voltage_hold

// ### testbench/vah_voltage_hold_chk.sv
`timescale 1ns/1ps
module vah_voltage_hold_chk #(
  parameter TICK_CYCLES = 4
) (
  input wire        aclk,
  input wire        aresetn,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        cycle_start,
  input wire        block_in,
  input wire [15:0] phase_three_current_freq,
  input wire [15:0] volt_amp_out_1,
  input wire [15:0] volt_amp_out_2,
  input wire [15:0] volt_amp_out_3,
  input wire [15:0] volt_ang_out_1,
  input wire [15:0] volt_ang_out_2,
  input wire [15:0] volt_ang_out_3,
  input wire        voltage_hold_on,
  input wire        fallback_mode,
  input wire        current_frequency_follow,
  input wire [15:0] sample_freq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg  [19:0] on_cnt_q;
  wire [19:0] on_cnt_d = voltage_hold_on ? on_cnt_q + 20'h1 : 20'h0;
  always @(posedge aclk) begin
    on_cnt_q <= aresetn ? on_cnt_d : 20'h0;
  end
  // Three cycles of hold so the one-cycle output latency has settled
  sequence s_held;
    voltage_hold_on [*3];
  endsequence
  sequence s_blk_seen;
    cycle_start && block_in;
  endsequence
  a_block_drop: assert property (s_blk_seen |-> ##[1:3] !voltage_hold_on)
    else $error("hold kept after block");
  a_amp_fixed: assert property (s_held |-> volt_amp_out_1 == volt_amp_out_2 &&
    volt_amp_out_2 == volt_amp_out_3 && $stable(volt_amp_out_1)) else $error("amplitude moved in hold");
  a_angle_frozen: assert property (s_held |-> $stable(volt_ang_out_1) &&
    $stable(volt_ang_out_2) && $stable(volt_ang_out_3)) else $error("angle moved in hold");
  a_hold_excl: assert property (!(voltage_hold_on && fallback_mode))
    else $error("hold and fallback together");
  a_fall_cause: assert property ($rose(fallback_mode) |-> $past(voltage_hold_on))
    else $error("fallback without hold");
  a_hold_limit: assert property (on_cnt_q <= 5001 * TICK_CYCLES + 3)
    else $error("hold beyond limit");
  a_freq_follow: assert property (current_frequency_follow && $past(current_frequency_follow) &&
    $past(phase_three_current_freq) == $past(phase_three_current_freq, 2)
    |-> sample_freq == $past(phase_three_current_freq)) else $error("sample freq not followed");
  a_rdata_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // vah_voltage_hold_chk

bind vah_voltage_hold vah_voltage_hold_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// ### testbench/vah_stage_model.sv
`timescale 1ns/1ps
module vah_stage_model (
  input  wire        aclk,
  input  wire        voltage_hold_on,
  input  wire        fallback_mode,
  input  wire [15:0] volt_amp_out_1,
  output logic       dir_mode_q
);
  // Direction is solvable while a reference exists; after expiry the stage trips non-directionally
  always @(posedge aclk) begin
    dir_mode_q <= !fallback_mode && (voltage_hold_on || volt_amp_out_1 != 16'h0000);
  end
endmodule // vah_stage_model

// ### testbench/vah_voltage_hold_test.sv
`timescale 1ns/1ps
`include "vah_defines.vh"
module vah_voltage_hold_test;
  localparam LO = 16'h0100;
  localparam HI = 16'h2710;
  logic        aclk = 1'b0, aresetn = 1'b0, cycle_start = 1'b0, block_in = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, rv;
  logic [1:0]  rs;
  logic [15:0] volt_mag_1 = HI, volt_mag_2 = HI, volt_mag_3 = HI, volt_ang_1 = 16'h1000;
  logic [15:0] volt_ang_2 = 16'h1100, volt_ang_3 = 16'h1200, cur_mag_1 = 16'h0, cur_mag_2 = 16'h0;
  logic [15:0] cur_mag_3 = 16'h0, phase_three_current_freq = 16'h1234;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] volt_amp_out_1, volt_amp_out_2, volt_amp_out_3, sample_freq;
  wire  [15:0] volt_ang_out_1, volt_ang_out_2, volt_ang_out_3;
  wire         voltage_hold_on, fallback_mode, current_frequency_follow, dir_mode_q;
  wire  [2:0]  st = {current_frequency_follow, fallback_mode, voltage_hold_on};
  int          num_errors = 0, num_checks = 0;

  vah_voltage_hold #(.TICK_CYCLES(4)) i_dut (.*);
  vah_stage_model i_stage (.*);

  always #20 aclk = ~aclk;

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  // Ready is sampled mid-cycle, where it equals what the next edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid && s_axi_rready;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("register", e, rv);
  endtask

  task automatic ev(input logic [31:0] m);
    rd(`VAH_OFF_EVT_STAT);
    chk("events", m, rv & m);
    wr(`VAH_OFF_EVT_CLR, m);
  endtask

  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (st[k] !== v && n < 300);
    chk("wait", 1, n < 300);
  endtask

  task automatic setv(input logic [15:0] m, input logic [15:0] m3, input logic [15:0] a);
    @(posedge aclk);
    volt_mag_1 <= m;
    volt_mag_2 <= m;
    volt_mag_3 <= m3;
    volt_ang_1 <= a;
    volt_ang_2 <= a + 16'h0100;
    volt_ang_3 <= a + 16'h0200;
  endtask

  task automatic pulse(input logic b);
    @(posedge aclk);
    block_in <= b;
    cycle_start <= 1'b1;
    @(posedge aclk);
    cycle_start <= 1'b0;
  endtask

  task automatic t_regs;
    rdc(`VAH_OFF_CTRL, `VAH_RST_CTRL);
    rdc(`VAH_OFF_FIX_FREQ, 32'h1388);
    rd(8'h40);
    chk("resp", 2'b10, rs);
    wr(8'h40, 32'h1);
    chk("bresp", 2'b10, rs);
    wr(`VAH_OFF_ACT_VOLT, 32'h1);
    rdc(`VAH_OFF_ACT_VOLT, 32'hC8);
    wr(`VAH_OFF_ACT_VOLT, 32'hFFFF);
    rdc(`VAH_OFF_ACT_VOLT, 32'h1388);
    wr(`VAH_OFF_HOLD_TIME, 32'h0);
    rdc(`VAH_OFF_HOLD_TIME, 32'h2);
    $display("register test done");
  endtask

  task automatic t_hold;
    wr(`VAH_OFF_ACT_VOLT, 32'h1000);
    wr(`VAH_OFF_EVT_EN, 32'hFFF);
    wr(`VAH_OFF_CTRL, 32'h71);
    ev(32'h1);
    setv(16'h0FFF, 16'h1000, 16'h1000);
    repeat (6) @(negedge aclk);
    chk("hold", 0, voltage_hold_on);
    setv(LO, 16'h0FFF, 16'h5000);
    wt(0, 1);
    @(negedge aclk);
    chk("amp", 32'h1000, volt_amp_out_2);
    chk("angle", 32'h1200, volt_ang_out_3);
    wt(1, 1);
    @(negedge aclk);
    chk("hold", 0, voltage_hold_on);
    chk("amp", LO, volt_amp_out_1);
    chk("stage", 0, dir_mode_q);
    chk("irq", 1, irq);
    rdc(`VAH_OFF_STATE, 32'h00120000);
    ev(32'h304);
    setv(HI, HI, 16'h1000);
    wt(1, 0);
    ev(32'h8);
    setv(LO, LO, 16'h1000);
    wt(0, 1);
    setv(HI, HI, 16'h1000);
    wt(0, 0);
    setv(LO, LO, 16'h1000);
    wt(0, 1);
    repeat (4) @(negedge aclk);
    chk("hold", 1, voltage_hold_on);
    setv(HI, HI, 16'h1000);
    wr(`VAH_OFF_EVT_CLR, 32'hFFF);
    $display("hold test done");
  endtask

  task automatic t_cur;
    wr(`VAH_OFF_HOLD_TIME, 32'h32);
    wr(`VAH_OFF_CTRL, 32'h73);
    setv(LO, LO, 16'h1000);
    repeat (6) @(negedge aclk);
    chk("hold", 0, voltage_hold_on);
    @(posedge aclk);
    cur_mag_2 <= 16'h00C8;
    wt(0, 1);
    ev(32'h10);
    @(posedge aclk);
    cur_mag_2 <= `VAH_RST_PICKUP;
    wt(0, 0);
    ev(32'h20);
    $display("current test done");
  endtask

  task automatic t_blk;
    wr(`VAH_OFF_CTRL, 32'h71);
    wt(0, 1);
    @(posedge aclk);
    block_in <= 1'b1;
    repeat (8) @(negedge aclk);
    chk("hold", 1, voltage_hold_on);
    pulse(1'b1);
    wt(0, 0);
    ev(32'h400);
    pulse(1'b0);
    wt(0, 1);
    ev(32'h800);
    setv(HI, HI, 16'h1000);
    $display("block test done");
  endtask

  task automatic t_follow;
    wr(`VAH_OFF_CTRL, 32'h75);
    setv(LO, LO, 16'h1000);
    wt(2, 1);
    @(negedge aclk);
    chk("freq", 32'h1234, sample_freq);
    ev(32'h40);
    setv(HI, HI, 16'h1000);
    wt(2, 0);
    @(negedge aclk);
    chk("freq", 32'h1388, sample_freq);
    ev(32'h80);
    wr(`VAH_OFF_EVT_EN, 32'h0);
    wr(`VAH_OFF_CTRL, 32'h70);
    chk("irq", 0, irq);
    wr(`VAH_OFF_EVT_EN, 32'h2);
    chk("irq", 1, irq);
    ev(32'h2);
    chk("irq", 0, irq);
    wr(`VAH_OFF_CTRL, 32'h31);
    setv(LO, HI, 16'h1000);
    wt(0, 1);
    setv(HI, HI, 16'h1000);
    wt(0, 0);
    $display("follow test done");
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_hold;
    t_cur;
    t_blk;
    t_follow;
    close_out;
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    close_out;
  end
endmodule // vah_voltage_hold_test
